//--- logic/nhc_pkg.sv
package nhc_pkg;
  localparam logic [7:0] NHC_CMD_READ1 = 8'h00;
  localparam logic [7:0] NHC_CMD_READ2 = 8'h30;
  localparam logic [7:0] NHC_CMD_PROG1 = 8'h80;
  localparam logic [7:0] NHC_CMD_PROG2 = 8'h10;
  localparam logic [7:0] NHC_CMD_ERASE1 = 8'h60;
  localparam logic [7:0] NHC_CMD_ERASE2 = 8'hD0;
  localparam logic [7:0] NHC_CMD_STATUS = 8'h70;
  localparam logic [7:0] NHC_CMD_RESET = 8'hFF;
  // Operation codes on the user port
  localparam logic [1:0] NHC_OP_READ = 2'h0;
  localparam logic [1:0] NHC_OP_PROG = 2'h1;
  localparam logic [1:0] NHC_OP_ERASE = 2'h2;
  localparam logic [1:0] NHC_OP_RESET = 2'h3;
  // Address field layout
  localparam int NHC_COL_W = 12;
  localparam int NHC_ROW_W = 19;
  localparam int NHC_DIE_BIT = 18;
  // Page size in bytes: 2K plus 64 spare
  localparam int NHC_PAGE_BYTES = 2048 + 64;
  // Strobe timing: one cycle low/high, in ns and cycles at 40 MHz
  localparam int NHC_CLK_NS = 25;
  localparam int NHC_STROBE_NS = 25;
  localparam int NHC_STROBE_CYC =
    (NHC_STROBE_NS + NHC_CLK_NS - 1) / NHC_CLK_NS;
  localparam int NHC_CNT_W = 12;
endpackage : nhc_pkg

//--- logic/nhc_fifo.sv
`timescale 1ns/1ps
module nhc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Handshake and status
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_r];

  // Pointers and storage
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem[wr_r] <= in_data;
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : nhc_fifo

//--- logic/nhc_host.sv
`timescale 1ns/1ps
module nhc_host import nhc_pkg::*; #(
  parameter int FIFO_DEPTH = 16,
  parameter int PAGE_BYTES = NHC_PAGE_BYTES,
  parameter bit DUAL_DIE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Operation request
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [1:0] op_code,
  input wire logic [NHC_COL_W-1:0] op_col,
  input wire logic [NHC_ROW_W-1:0] op_row,
  input wire logic [NHC_CNT_W:0] op_len,
  output logic op_done,
  // Program data in
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  // Read data out
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // Flash pins
  output logic chip_sel_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic output_strobe_n,
  output logic write_protect_n,
  input wire logic ready_busy,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe
);
  typedef enum {
    NHC_IDLE, NHC_CMD1, NHC_ADDR, NHC_WDATA, NHC_CMD2, NHC_WAIT,
    NHC_RDATA, NHC_DONE
  } nhc_state_e;

  typedef struct packed {
    nhc_state_e st;
    logic [1:0] op;
    logic [2:0] acnt;
    logic [2:0] alast;
    logic [NHC_CNT_W:0] bcnt;
    logic [NHC_COL_W-1:0] col;
    logic [NHC_ROW_W-1:0] row;
    logic [1:0] ph;
    logic busy_seen;
    logic cs_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] dout;
    logic oe;
    logic done;
    logic [7:0] cap;
    logic cap_v;
  } nhc_state_s;

  nhc_state_s s_r;
  nhc_state_s s_nxt;
  logic rf_in_ready;
  logic wf_valid;
  logic [7:0] wf_data;
  logic wf_pop;
  logic [7:0] abyte;

  // Write data buffer between user and flash
  nhc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clk(clk),
    .reset(reset),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(wf_valid),
    .out_ready(wf_pop),
    .out_data(wf_data)
  );

  // Read data buffer; full stalls the read strobe
  nhc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rfifo (
    .clk(clk),
    .reset(reset),
    .in_valid(s_r.cap_v),
    .in_ready(rf_in_ready),
    .in_data(s_r.cap),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // Address byte for the current cycle, unused bits low
  always_comb begin
    abyte = 8'h00;
    unique case (s_r.acnt)
      3'd0: abyte = s_r.col[7:0];
      3'd1: abyte = {4'h0, s_r.col[11:8]};
      3'd2: abyte = s_r.row[7:0];
      3'd3: abyte = s_r.row[15:8];
      3'd4: abyte = {5'h00, DUAL_DIE ? s_r.row[NHC_DIE_BIT] : 1'b0,
                     s_r.row[17:16]};
      default: abyte = 8'h00;
    endcase
  end

  assign op_ready = (s_r.st == NHC_IDLE) && ready_busy;
  assign wf_pop = (s_r.st == NHC_WDATA) && (s_r.ph == 2'd0) && wf_valid;

  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.cap_v = 1'b0;
    unique case (s_r.st)
      NHC_IDLE: begin
        s_nxt.cs_n = 1'b1;
        s_nxt.oe = 1'b0;
        s_nxt.wp_n = 1'b1;
        if (op_valid && op_ready) begin
          s_nxt.op = op_code;
          s_nxt.col = op_col;
          s_nxt.row = op_row;
          s_nxt.bcnt = (op_len > (NHC_CNT_W+1)'(PAGE_BYTES)) ?
            (NHC_CNT_W+1)'(PAGE_BYTES) : op_len;
          s_nxt.acnt = (op_code == NHC_OP_ERASE) ? 3'd2 : 3'd0;
          s_nxt.alast = 3'd4;
          s_nxt.ph = 2'd0;
          s_nxt.cs_n = 1'b0;
          s_nxt.st = NHC_CMD1;
        end
      end
      NHC_CMD1, NHC_CMD2, NHC_ADDR, NHC_WDATA: begin
        // Strobe: phase 0 drive low, phase 1 raise (device latches)
        if (s_r.ph == 2'd0) begin
          s_nxt.cle = (s_r.st == NHC_CMD1) || (s_r.st == NHC_CMD2);
          s_nxt.ale = (s_r.st == NHC_ADDR);
          s_nxt.oe = 1'b1;
          if (s_r.st == NHC_CMD1) begin
            unique case (s_r.op)
              NHC_OP_READ: s_nxt.dout = NHC_CMD_READ1;
              NHC_OP_PROG: s_nxt.dout = NHC_CMD_PROG1;
              NHC_OP_ERASE: s_nxt.dout = NHC_CMD_ERASE1;
              NHC_OP_RESET: s_nxt.dout = NHC_CMD_RESET;
            endcase
          end else if (s_r.st == NHC_CMD2) begin
            unique case (s_r.op)
              NHC_OP_READ: s_nxt.dout = NHC_CMD_READ2;
              NHC_OP_PROG: s_nxt.dout = NHC_CMD_PROG2;
              default: s_nxt.dout = NHC_CMD_ERASE2;
            endcase
          end else if (s_r.st == NHC_ADDR) begin
            s_nxt.dout = abyte;
          end else begin
            s_nxt.dout = wf_data;
          end
          // Data phase waits for buffered write data
          if (s_r.st != NHC_WDATA || wf_valid) begin
            s_nxt.we_n = 1'b0;
            s_nxt.ph = 2'd1;
          end
        end else begin
          s_nxt.we_n = 1'b1;
          s_nxt.ph = 2'd0;
          if (s_r.st == NHC_CMD1) begin
            s_nxt.st = (s_r.op == NHC_OP_RESET) ? NHC_WAIT : NHC_ADDR;
            s_nxt.busy_seen = 1'b0;
          end else if (s_r.st == NHC_ADDR) begin
            s_nxt.acnt = s_r.acnt + 3'd1;
            if (s_r.acnt == s_r.alast) begin
              s_nxt.st = (s_r.op == NHC_OP_PROG && s_r.bcnt != '0) ?
                NHC_WDATA : NHC_CMD2;
            end
          end else if (s_r.st == NHC_WDATA) begin
            s_nxt.bcnt = s_r.bcnt - 1'b1;
            if (s_r.bcnt == (NHC_CNT_W+1)'(1)) begin
              s_nxt.st = NHC_CMD2;
            end
          end else begin
            s_nxt.st = NHC_WAIT;
            s_nxt.busy_seen = 1'b0;
          end
        end
      end
      NHC_WAIT: begin
        // Release bus, wait for busy then ready
        s_nxt.cle = 1'b0;
        s_nxt.ale = 1'b0;
        s_nxt.oe = 1'b0;
        if (!ready_busy) begin
          s_nxt.busy_seen = 1'b1;
        end
        if (s_r.busy_seen && ready_busy) begin
          s_nxt.st = (s_r.op == NHC_OP_READ && s_r.bcnt != '0) ?
            NHC_RDATA : NHC_DONE;
          s_nxt.ph = 2'd0;
        end
      end
      NHC_RDATA: begin
        // Fall drives a byte; sample before the rise
        if (s_r.ph == 2'd0) begin
          // Hold off while the last byte is still being pushed
          if (rf_in_ready && !s_r.cap_v) begin
            s_nxt.re_n = 1'b0;
            s_nxt.ph = 2'd1;
          end
        end else begin
          s_nxt.cap = io_in;
          s_nxt.cap_v = 1'b1;
          s_nxt.re_n = 1'b1;
          s_nxt.ph = 2'd0;
          s_nxt.bcnt = s_r.bcnt - 1'b1;
          if (s_r.bcnt == (NHC_CNT_W+1)'(1)) begin
            s_nxt.st = NHC_DONE;
          end
        end
      end
      NHC_DONE: begin
        s_nxt.cs_n = 1'b1;
        s_nxt.done = 1'b1;
        s_nxt.st = NHC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '{st: NHC_IDLE, op: 2'h0, acnt: 3'h0, alast: 3'h0,
               bcnt: '0, col: '0, row: '0, ph: 2'h0, busy_seen: 1'b0,
               cs_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
               wp_n: 1'b0, dout: 8'h00, oe: 1'b0, done: 1'b0,
               cap: 8'h00, cap_v: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin drive from flops
  assign chip_sel_n = s_r.cs_n;
  assign cmd_latch = s_r.cle;
  assign addr_latch = s_r.ale;
  assign write_strobe_n = s_r.we_n;
  assign output_strobe_n = s_r.re_n;
  assign write_protect_n = s_r.wp_n;
  assign io_out = s_r.dout;
  assign io_oe = s_r.oe;
  assign op_done = s_r.done;
endmodule : nhc_host

//--- dv/nhc_dev_model.sv
`timescale 1ns/1ps
module nhc_dev_model (
  // Strobes and latches from the host
  input wire logic chip_sel_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic write_protect_n,
  input wire logic [7:0] io_host,
  // Lines back to the host
  output logic [7:0] io_dev,
  output logic ready_busy
);
  logic [7:0] cmd_log [$];
  logic [7:0] addr_log [$];
  logic [7:0] data_log [$];
  logic [11:0] col_r = 12'h000;
  logic busy_r = 1'b0;
  logic drv_r = 1'b0;
  logic die_r = 1'b0;
  logic [7:0] last_r = 8'h00;
  // Open-drain status with pull-up, valid when deselected
  assign ready_busy = busy_r ? 1'b0 : 1'b1;
  // Released bus shows the inverse of the last byte
  assign io_dev = drv_r ? last_r : ~last_r;
  // Capture only on the write strobe rise
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n) begin
      if (cmd_latch) begin
        cmd_log.push_back(io_host);
        if (io_host inside {8'h30, 8'hFF} || (write_protect_n &&
            io_host inside {8'h10, 8'hD0})) begin
          busy_r = 1'b1;
        end
      end else if (addr_latch) begin
        if (addr_log.size() < 5) addr_log.push_back(io_host);
        if (addr_log.size() == 2) begin
          col_r = {addr_log[1][3:0], addr_log[0]};
        end
        // Die choice from the fifth cycle; this model is die zero
        if (addr_log.size() == 5) die_r = addr_log[4][2];
      end else begin
        data_log.push_back(io_host);
        col_r = col_r + 12'h001;
      end
    end
  end
  // Busy runs to its end whatever chip select does
  always @(posedge busy_r) begin
    #500;
    busy_r = 1'b0;
  end
  // Next byte out on each read strobe fall while selected and on die zero
  always @(negedge output_strobe_n) begin
    if (!chip_sel_n && !die_r) begin
      drv_r = 1'b1;
      last_r = col_r[7:0] ^ 8'hA5;
      col_r = col_r + 12'h001;
    end
  end
  // Let go of the bus after the hold time
  always @(posedge output_strobe_n) begin
    #5;
    drv_r = 1'b0;
  end
endmodule : nhc_dev_model

//--- dv/nhc_host_asserts.sv
`timescale 1ns/1ps
module nhc_host_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic chip_sel_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic write_protect_n,
  input wire logic ready_busy,
  input wire logic [7:0] io_out,
  input wire logic io_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // One low cycle, then high
  sequence we_pulse;
    !write_strobe_n ##1 write_strobe_n;
  endsequence
  sequence re_pulse;
    !output_strobe_n ##1 output_strobe_n;
  endsequence
  we_pulse_a: assert property ($fell(write_strobe_n) |-> we_pulse)
    else $error("write strobe low too long");
  we_hold_a: assert property ($rose(write_strobe_n) |->
    $stable(io_out) && $stable(cmd_latch) && $stable(addr_latch) && io_oe)
    else $error("bus moved at the write strobe rise");
  re_pulse_a: assert property ($fell(output_strobe_n) |-> re_pulse)
    else $error("read strobe low too long");
  sel_low_a: assert property (!write_strobe_n || !output_strobe_n |->
    !chip_sel_n) else $error("strobe without chip select");
  latch_excl_a: assert property (cmd_latch |-> !addr_latch)
    else $error("both latch enables high");
  read_float_a: assert property (!output_strobe_n |-> !io_oe)
    else $error("host drives bus during read");
  start_gate_a: assert property (op_ready |-> ready_busy && chip_sel_n)
    else $error("ready while device busy or selected");
  wp_high_a: assert property (!chip_sel_n |-> write_protect_n)
    else $error("write protect low while selected");
  done_ready_a: assert property (op_done |-> ready_busy ##1 !op_done)
    else $error("done while busy or too long");
  reset_idle_a: assert property (disable iff (1'b0) reset |=>
    chip_sel_n && !io_oe && !write_protect_n)
    else $error("pins active after reset");
endmodule : nhc_host_asserts
bind nhc_host nhc_host_asserts i_chk (.clk, .reset, .op_ready, .op_done,
  .chip_sel_n, .cmd_latch, .addr_latch, .write_strobe_n,
  .output_strobe_n, .write_protect_n, .ready_busy, .io_out, .io_oe);

//--- dv/test_nand_pin_interface_addressing.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin \
  mismatches++; $display("mismatch %0t %s", $time, m); end end
module test_nand_pin_interface_addressing import nhc_pkg::*; ;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
  logic [1:0] op_code = 2'h0;
  logic [NHC_COL_W-1:0] op_col = '0;
  logic [NHC_ROW_W-1:0] op_row = '0;
  logic [NHC_CNT_W:0] op_len = '0;
  logic [7:0] wr_data = 8'h00;
  logic op_ready, op_done, wr_ready, rd_valid, chip_sel_n, cmd_latch;
  logic addr_latch, write_strobe_n, output_strobe_n, write_protect_n;
  logic io_oe, ready_busy;
  logic [7:0] rd_data, io_out, io_in, dev_io;
  logic [31:0] seed = 32'hC512;
  logic [7:0] exp_q [$];
  logic [7:0] c1 [4] = '{8'h00, 8'h80, 8'h60, 8'hFF};
  logic [7:0] c2 [4] = '{8'h30, 8'h10, 8'hD0, 8'hFF};
  int na [4] = '{5, 5, 3, 0};
  int mismatches = 0, num_checks = 0, nf = 0;
  nhc_host i_dut (.clk, .reset, .op_valid, .op_ready, .op_code, .op_col,
    .op_row, .op_len, .op_done, .wr_valid, .wr_ready, .wr_data, .rd_valid,
    .rd_ready, .rd_data, .chip_sel_n, .cmd_latch, .addr_latch,
    .write_strobe_n, .output_strobe_n, .write_protect_n, .ready_busy,
    .io_in, .io_out, .io_oe);
  nhc_dev_model i_dev (.chip_sel_n, .cmd_latch, .addr_latch,
    .write_strobe_n, .output_strobe_n, .write_protect_n, .io_host(io_out),
    .io_dev(dev_io), .ready_busy);
  // Host drives the bus when enabled, else the device
  assign io_in = io_oe ? io_out : dev_io;
  always #12.5 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Stalling drain; compare each byte with the oldest note
  always @(posedge clk) begin
    seed <= xs(seed);
    rd_ready <= seed[3] & seed[4];
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      `CHK(rd_data, exp_q.pop_front(), "read byte")
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : bound
  // Fill the write buffer until it refuses
  task automatic fill_wr();
    @(posedge clk);
    for (nf = 0; nf < 40; nf++) begin
      wr_data <= nf[7:0] ^ 8'h3C;
      wr_valid <= 1'b1;
      @(negedge clk);
      if (wr_ready !== 1'b1) break;
      @(posedge clk);
    end
    @(posedge clk);
    wr_valid <= 1'b0;
    `CHK(nf, 16, "write buffer depth")
  endtask : fill_wr
  task automatic run_op(input logic [1:0] c, input int len);
    logic [11:0] col;
    logic [18:0] row;
    logic [7:0] e [5];
    int k;
    int off;
    col = {1'b0, seed[10:0]};
    row = {1'b0, seed[29:12]};
    e = '{col[7:0], {4'h0, col[11:8]}, row[7:0], row[15:8],
      {5'h00, row[18:16]}};
    off = (c == NHC_OP_ERASE) ? 2 : 0;
    i_dev.cmd_log.delete();
    i_dev.addr_log.delete();
    i_dev.data_log.delete();
    for (k = 0; k < len && c == NHC_OP_READ; k++) begin
      exp_q.push_back(8'(col + k) ^ 8'hA5);
    end
    @(posedge clk);
    op_code <= c;
    op_col <= col;
    op_row <= row;
    op_len <= len[12:0];
    op_valid <= 1'b1;
    @(negedge clk);
    for (k = 0; k < 100 && op_ready !== 1'b1; k++) @(negedge clk);
    bound(k, 100);
    @(posedge clk);
    op_valid <= 1'b0;
    @(negedge clk);
    for (k = 0; k < 9000 && op_done !== 1'b1; k++) @(negedge clk);
    bound(k, 9000);
    for (k = 0; k < 500 && exp_q.size() > 0; k++) @(negedge clk);
    bound(k, 500);
    `CHK(i_dev.cmd_log[0], c1[c], "first command")
    if (c != NHC_OP_RESET) begin
      `CHK(i_dev.cmd_log[1], c2[c], "second command")
    end
    `CHK(i_dev.addr_log.size(), na[c], "address count")
    for (k = 0; k < na[c]; k++) begin
      `CHK(i_dev.addr_log[k], e[k + off], "address byte")
    end
    for (k = 0; k < i_dev.data_log.size(); k++) begin
      `CHK(i_dev.data_log[k], k[7:0] ^ 8'h3C, "program data")
    end
    if (c == NHC_OP_PROG) `CHK(i_dev.data_log.size(), 16, "data count")
  endtask : run_op
  // Read, program, erase and reset in turn
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      if (c == 1) fill_wr();
      run_op(c[1:0], c == 0 ? 40 : (c == 1 ? nf : 0));
      $display("test %0d ended", c);
    end
    tally_and_finish();
  end
endmodule : test_nand_pin_interface_addressing
